//--- verification/port_manager_model.sv
// Port manager model: issues single-byte register accesses.
// Assumes the bank takes a request at the rising edge it sees it.
`timescale 1ns/1ps
module port_manager_model (
    input  wire logic       clock,
    input  wire logic [7:0] reg_rdata,
    output logic      [7:0] reg_addr,
    output logic            reg_write,
    output logic            reg_read,
    output logic      [7:0] reg_wdata
);
    initial begin
        reg_addr = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 8'h00;
    end
    // Data is inverted after release so stale bytes never look valid
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(posedge clock);
        #1 d = reg_rdata;
    endtask
endmodule

//--- verification/port_regs_asserts.sv
// Concurrent checks on the port register bank outputs.
// Assumes only the bank's ports; bound at the foot of this file.
`timescale 1ns/1ps
module port_regs_asserts (
    input wire logic       clock,
    input wire logic       reset,
    input wire logic       software_reset,
    input wire logic       hard_reset_rx,
    input wire logic [7:0] reg_addr,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] power_status,
    input wire logic [7:0] fault_status,
    input wire logic       power_alert,
    input wire logic       fault_alert,
    input wire logic       outputs_oe,
    input wire logic       watchdog_enable,
    input wire logic       selftest_rx_mode,
    input wire logic       cable_power_to_first,
    input wire logic       monitor_second_pin
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    // A write that no sync reset overrides in the same cycle
    wire cfg_wr  = reg_write && !software_reset && reg_addr == 8'h18;
    wire ctrl_wr = reg_write && !software_reset && reg_addr == 8'h19;
    chk_pwr_quiet: assert property ($past(power_status) == 8'h00
        |-> !power_alert) else $error("power alert without status");
    chk_fault_quiet: assert property ($past(fault_status) == 8'h00
        |-> !fault_alert) else $error("fault alert without status");
    chk_tri_write: assert property (cfg_wr && reg_wdata[7]
        |-> ##2 !outputs_oe) else $error("outputs still driven");
    chk_dog_write: assert property (ctrl_wr && reg_wdata[5]
        |-> ##2 watchdog_enable) else $error("watchdog not enabled");
    chk_test_write: assert property (ctrl_wr && !reg_wdata[1]
        |-> ##2 !selftest_rx_mode) else $error("self-test mode stuck");
    chk_pin_pair: assert property (monitor_second_pin
        == cable_power_to_first) else $error("pin routing split");
    chk_stretch_zero: assert property (reg_read && reg_addr == 8'h19
        ##1 !reg_read |=> reg_rdata[3:2] == 2'b00)
        else $error("stretch field not zero");
    chk_fault_rsvd: assert property (reg_read && reg_addr == 8'h15
        ##1 !reg_read |=> (reg_rdata & 8'h4C) == 8'h00)
        else $error("fault mask reserved bit set");
    chk_sw_clear: assert property (software_reset
        |-> ##2 !watchdog_enable && !selftest_rx_mode)
        else $error("control kept after software reset");
    chk_hard_keep: assert property (hard_reset_rx && !software_reset
        && !reg_write |-> ##2 $stable(watchdog_enable))
        else $error("control lost on hard reset");
endmodule
bind port_mask_output_ctrl_regs port_regs_asserts port_regs_asserts_i (
    .clock, .reset, .software_reset, .hard_reset_rx, .reg_addr, .reg_write,
    .reg_read, .reg_wdata, .reg_rdata, .power_status, .fault_status,
    .power_alert, .fault_alert, .outputs_oe, .watchdog_enable,
    .selftest_rx_mode, .cable_power_to_first, .monitor_second_pin);

//--- verification/tb.sv
// Self-checking bench for the port mask and output control registers.
// Assumes the port manager model carries every register access.
`timescale 1ns/1ps
module tb;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       software_reset = 1'b0;
    logic       hard_reset_rx = 1'b0;
    logic [7:0] power_status = 8'h00;
    logic [7:0] fault_status = 8'h00;
    logic       accessory_detect_n = 1'b1;
    logic       own_flip = 1'b0;
    logic [1:0] own_mux = 2'b00;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_val;
    logic       reg_write, reg_read, power_alert, fault_alert, plug_flip;
    logic       accessory_indicator, accessory_indicator_oe, outputs_oe;
    logic       lane_sel_zero, lane_sel_one, watchdog_enable;
    logic       selftest_rx_mode, cable_power_to_first, monitor_second_pin;
    int         bad_count = 0;
    int         samples_checked = 0;
    always #25 clock = ~clock;
    port_manager_model port_manager_model_i (.clock, .reg_rdata,
        .reg_addr, .reg_write, .reg_read, .reg_wdata);
    port_mask_output_ctrl_regs port_mask_output_ctrl_regs_i (.clock,
        .reset, .software_reset, .hard_reset_rx, .reg_addr, .reg_write,
        .reg_read, .reg_wdata, .reg_rdata, .power_status, .fault_status,
        .accessory_detect_n, .own_flip, .own_mux, .power_alert,
        .fault_alert, .accessory_indicator, .accessory_indicator_oe,
        .lane_sel_zero, .lane_sel_one, .plug_flip, .outputs_oe,
        .watchdog_enable, .selftest_rx_mode, .cable_power_to_first,
        .monitor_second_pin);
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        port_manager_model_i.write_reg(a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        port_manager_model_i.read_reg(a, rd_val);
        check(rd_val, exp);
    endtask
    // Derived outputs land one edge after the register itself
    task automatic settle;
        repeat (2) @(posedge clock);
        #1;
    endtask
    task automatic give_verdict;
        if (bad_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        rdc(8'h14, 8'hFF);
        rdc(8'h15, 8'hB3);
        rdc(8'h18, 8'h40);
        rdc(8'h19, 8'h00);
        rdc(8'h16, 8'h00);
        check({6'h0, outputs_oe, accessory_indicator}, 8'h03);
        wr(8'h15, 8'hFF);
        rdc(8'h15, 8'hB3);
        wr(8'h19, 8'hFF);
        rdc(8'h19, 8'h33);
        check({4'h0, watchdog_enable, selftest_rx_mode, cable_power_to_first,
            monitor_second_pin}, 8'h0F);
        for (int i = 0; i < 4; i++) begin
            wr(8'h18, {4'h4, i[1:0], 1'b0, i[0]});
            settle;
            check({5'h0, lane_sel_one, lane_sel_zero, plug_flip},
                {5'h0, i[1:0], i[0]});
        end
        wr(8'h18, 8'h00);
        settle;
        check({7'h0, accessory_indicator}, 8'h00);
        wr(8'h18, 8'h80);
        settle;
        check({6'h0, outputs_oe, accessory_indicator_oe}, 8'h00);
        @(posedge clock) power_status <= 8'h01;
        fault_status <= 8'h02;
        settle;
        check({6'h0, power_alert, fault_alert}, 8'h03);
        wr(8'h14, 8'hFE);
        wr(8'h15, 8'h00);
        settle;
        check({6'h0, power_alert, fault_alert}, 8'h00);
        @(posedge clock) hard_reset_rx <= 1'b1;
        @(posedge clock) hard_reset_rx <= 1'b0;
        settle;
        check({6'h0, power_alert, fault_alert}, 8'h03);
        rdc(8'h19, 8'h33);
        wr(8'h19, 8'h00);
        wr(8'h18, 8'h40);
        rdc(8'h18, 8'h00);
        @(posedge clock) accessory_detect_n <= 1'b0;
        own_mux <= 2'b10;
        own_flip <= 1'b1;
        settle;
        check({7'h0, accessory_indicator}, 8'h00);
        check({5'h0, lane_sel_one, lane_sel_zero, plug_flip}, 8'h05);
        @(posedge clock) accessory_detect_n <= 1'b1;
        settle;
        check({7'h0, accessory_indicator}, 8'h01);
        wr(8'h14, 8'h00);
        rdc(8'h14, 8'h00);
        @(posedge clock) software_reset <= 1'b1;
        @(posedge clock) software_reset <= 1'b0;
        rdc(8'h14, 8'hFF);
        rdc(8'h18, 8'h40);
        give_verdict;
    end
    // Run needs about 110 cycles; this bound is far above that
    initial begin
        #200000;
        bad_count++;
        give_verdict;
    end
endmodule

//--- verilog/port_mask_output_ctrl_regs.sv
// Port mask, standard output configuration and port control registers.
// Assumes a same-clock register access port (address, write and read
// strobes, write data) from the serial bus engine, and same-clock status
// inputs from the power, fault and accessory detection logic.
`timescale 1ns/1ps

module port_mask_output_ctrl_regs (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       software_reset,
    input  wire logic       hard_reset_rx,
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    input  wire logic [7:0] power_status,
    input  wire logic [7:0] fault_status,
    input  wire logic       accessory_detect_n,
    input  wire logic       own_flip,
    input  wire logic [1:0] own_mux,
    output logic            power_alert,
    output logic            fault_alert,
    output logic            accessory_indicator,
    output logic            accessory_indicator_oe,
    output logic            lane_sel_zero,
    output logic            lane_sel_one,
    output logic            plug_flip,
    output logic            outputs_oe,
    output logic            watchdog_enable,
    output logic            selftest_rx_mode,
    output logic            cable_power_to_first,
    output logic            monitor_second_pin
);

    logic [7:0] pwr_mask_r;     // Power status interrupt mask
    logic [7:0] fault_mask_r;   // Fault status interrupt mask
    logic [7:0] out_cfg_r;      // Standard output configuration
    logic [7:0] port_ctrl_r;    // Port control
    logic [7:0] out_cfg_nxt;    // Output config after a write
    logic       owner;          // Processor owns the standard outputs
    logic       mask_clear;     // Events that restore the masks
    logic       ctrl_clear;     // Events that restore port control
    logic       wr_pwr;
    logic       wr_fault;
    logic       wr_cfg;
    logic       wr_ctrl;

    assign owner      = port_ctrl_r[port_regs_pkg::CTRL_OWNER_BIT];
    assign mask_clear = software_reset | hard_reset_rx;
    // Hard reset deliberately left out here
    assign ctrl_clear = software_reset;
    assign wr_pwr   = reg_write && reg_addr == port_regs_pkg::ADDR_PWR_MASK;
    assign wr_fault = reg_write
                      && reg_addr == port_regs_pkg::ADDR_FAULT_MASK;
    assign wr_cfg   = reg_write && reg_addr == port_regs_pkg::ADDR_OUT_CFG;
    assign wr_ctrl  = reg_write && reg_addr == port_regs_pkg::ADDR_PORT_CTRL;

    // Merge a config write; the accessory bit is kept unless owned
    always_comb begin
        out_cfg_nxt = (out_cfg_r & ~port_regs_pkg::WMASK_OUT_CFG)
                    | (reg_wdata & port_regs_pkg::WMASK_OUT_CFG);
        if (!owner) begin
            out_cfg_nxt[port_regs_pkg::OUT_ACCESSORY_BIT] =
                out_cfg_r[port_regs_pkg::OUT_ACCESSORY_BIT];
        end
    end

    // Power status mask
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            pwr_mask_r <= port_regs_pkg::RST_PWR_MASK;
        end else if (mask_clear) begin
            pwr_mask_r <= port_regs_pkg::RST_PWR_MASK;
        end else if (wr_pwr) begin
            pwr_mask_r <= reg_wdata;
        end
    end

    // Fault status mask; reserved bits never take a one
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            fault_mask_r <= port_regs_pkg::RST_FAULT_MASK;
        end else if (mask_clear) begin
            fault_mask_r <= port_regs_pkg::RST_FAULT_MASK;
        end else if (wr_fault) begin
            fault_mask_r <= reg_wdata & port_regs_pkg::WMASK_FAULT;
        end
    end

    // Output configuration; not restored by hard reset
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            out_cfg_r <= port_regs_pkg::RST_OUT_CFG;
        end else if (ctrl_clear) begin
            out_cfg_r <= port_regs_pkg::RST_OUT_CFG;
        end else if (wr_cfg) begin
            out_cfg_r <= out_cfg_nxt;
        end
    end

    // Port control; stretch field and top bits never take a one
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            port_ctrl_r <= port_regs_pkg::RST_PORT_CTRL;
        end else if (ctrl_clear) begin
            port_ctrl_r <= port_regs_pkg::RST_PORT_CTRL;
        end else if (wr_ctrl) begin
            // Stretch field and top bits are masked off on every write
            port_ctrl_r <= reg_wdata
                           & port_regs_pkg::WMASK_PORT_CTRL;
        end
    end

    // Read data, registered; unmapped offsets read zero
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                port_regs_pkg::ADDR_PWR_MASK:   reg_rdata <= pwr_mask_r;
                port_regs_pkg::ADDR_FAULT_MASK: reg_rdata <= fault_mask_r;
                port_regs_pkg::ADDR_OUT_CFG:    reg_rdata <= out_cfg_r;
                // Stretch field is stored as zero, so it reads 00b
                port_regs_pkg::ADDR_PORT_CTRL:  reg_rdata <= port_ctrl_r;
                default:                        reg_rdata <= 8'h00;
            endcase
        end
    end

    // Alert flags follow status gated by mask, one cycle later
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            power_alert <= 1'b0;
            fault_alert <= 1'b0;
        end else begin
            power_alert <= |(power_status & pwr_mask_r);
            fault_alert <= |(fault_status & fault_mask_r);
        end
    end

    // Standard output pins; the owner bit picks the source
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            accessory_indicator    <= 1'b1;
            accessory_indicator_oe <= 1'b0;
            lane_sel_zero          <= 1'b0;
            lane_sel_one           <= 1'b0;
            plug_flip              <= 1'b0;
            outputs_oe             <= 1'b0;
        end else begin
            // Tristate hides all pins whoever owns them
            outputs_oe <= ~out_cfg_r[port_regs_pkg::OUT_TRISTATE_BIT];
            accessory_indicator_oe <=
                ~out_cfg_r[port_regs_pkg::OUT_TRISTATE_BIT];
            if (owner) begin
                accessory_indicator <=
                    out_cfg_r[port_regs_pkg::OUT_ACCESSORY_BIT];
                lane_sel_zero <= out_cfg_r[port_regs_pkg::OUT_MUX_LO];
                lane_sel_one  <=
                    out_cfg_r[port_regs_pkg::OUT_MUX_LO + 1];
                plug_flip <= out_cfg_r[port_regs_pkg::OUT_FLIP_BIT];
            end else begin
                accessory_indicator <= accessory_detect_n;
                lane_sel_zero       <= own_mux[0];
                lane_sel_one        <= own_mux[1];
                plug_flip           <= own_flip;
            end
        end
    end

    // Port control outputs to watchdog, receiver and cable power switch
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            watchdog_enable      <= 1'b0;
            selftest_rx_mode     <= 1'b0;
            cable_power_to_first <= 1'b0;
            monitor_second_pin   <= 1'b0;
        end else begin
            watchdog_enable <=
                port_ctrl_r[port_regs_pkg::CTRL_WATCHDOG_BIT];
            // Receiver drops the buffer after its acknowledgement when set
            selftest_rx_mode <=
                port_ctrl_r[port_regs_pkg::CTRL_SELFTEST_BIT];
            cable_power_to_first <=
                port_ctrl_r[port_regs_pkg::CTRL_PLUG_FLIP_BIT];
            monitor_second_pin <=
                port_ctrl_r[port_regs_pkg::CTRL_PLUG_FLIP_BIT];
        end
    end

endmodule

//--- verilog/port_regs_pkg.sv
// Package for the port mask and output control register bank.
// Assumes an 8-bit register access port driven from the serial bus engine.
package port_regs_pkg;
    // Register offsets on the management bus
    localparam logic [7:0] ADDR_PWR_MASK   = 8'h14;
    localparam logic [7:0] ADDR_FAULT_MASK = 8'h15;
    localparam logic [7:0] ADDR_OUT_CFG    = 8'h18;
    localparam logic [7:0] ADDR_PORT_CTRL  = 8'h19;
    // Values after reset
    localparam logic [7:0] RST_PWR_MASK    = 8'hFF;
    localparam logic [7:0] RST_FAULT_MASK  = 8'hB3;
    localparam logic [7:0] RST_OUT_CFG     = 8'h40;
    localparam logic [7:0] RST_PORT_CTRL   = 8'h00;
    // Writable bits per register
    localparam logic [7:0] WMASK_FAULT     = 8'hB3;
    localparam logic [7:0] WMASK_OUT_CFG   = 8'hCD;
    localparam logic [7:0] WMASK_PORT_CTRL = 8'h33;
    // Field positions of the output configuration
    localparam int OUT_TRISTATE_BIT  = 7;
    localparam int OUT_ACCESSORY_BIT = 6;
    localparam int OUT_MUX_LO        = 2;
    localparam int OUT_FLIP_BIT      = 0;
    // Field positions of the port control
    localparam int CTRL_WATCHDOG_BIT = 5;
    localparam int CTRL_OWNER_BIT    = 4;
    localparam int CTRL_SELFTEST_BIT = 1;
    localparam int CTRL_PLUG_FLIP_BIT   = 0;
endpackage
